// ### include/dtc_regs.svh
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

// byte offsets on the register bus
`define DTC_OFS_CTRL        4'h0
`define DTC_OFS_LAT         4'h4
`define DTC_OFS_STATUS      4'h8

// control register fields
`define DTC_CTRL_DLL_OFF    0
`define DTC_CTRL_PRE2       1
`define DTC_CTRL_CRC        2
`define DTC_CTRL_WTSEL_LO   3
`define DTC_CTRL_WTSEL_HI   4
`define DTC_CTRL_MASK       32'h0000001F
`define DTC_CTRL_RST        32'h00000000

// latency register fields
`define DTC_LAT_CWL_LO      0
`define DTC_LAT_CWL_HI      5
`define DTC_LAT_AL_LO       8
`define DTC_LAT_AL_HI       13
`define DTC_LAT_PL_LO       16
`define DTC_LAT_PL_HI       19
`define DTC_LAT_MASK        32'h000F3F3F
`define DTC_LAT_RST         32'h00000009

// status register fields
`define DTC_STAT_SEL_LO     0
`define DTC_STAT_SEL_HI     1
`define DTC_STAT_TRANS      2
`define DTC_STAT_WR_LIVE    3

// write termination latencies in clocks
`define DTC_ON_SUB_PRE1     8'h02
`define DTC_ON_SUB_PRE2     8'h03
`define DTC_CHOP_P1_NOCRC   8'h04
`define DTC_CHOP_P1_CRC     8'h07
`define DTC_CHOP_P2_NOCRC   8'h05
`define DTC_CHOP_P2_CRC     8'h08
`define DTC_FULL_P1_NOCRC   8'h06
`define DTC_FULL_P1_CRC     8'h07
`define DTC_FULL_P2_NOCRC   8'h07
`define DTC_FULL_P2_CRC     8'h08

// asynchronous windows, longest figure in ns
`define DTC_CLK_PERIOD_NS   8
`define DTC_ASYNC_ON_MAX_NS  9
`define DTC_ASYNC_OFF_MAX_NS 9

`endif

// ### include/dtc_pkg.sv
package dtc_pkg;

   typedef enum logic [1:0] {
      DTC_TERM_PARK,
      DTC_TERM_NOM,
      DTC_TERM_WR
   } dtc_term_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } dtc_avs_req_t;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } dtc_avs_rsp_t;

   typedef struct packed {
      logic write_cmd;
      logic chop4;
      logic term_pin;
   } dtc_link_t;

   typedef struct packed {
      dtc_term_t sel;
      logic      transitioning;
      logic      wr_window;
   } dtc_term_out_t;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] lat;
      logic        waitreq;
      logic [31:0] rdata;
      logic [7:0]  wr_cnt;
      logic [7:0]  wr_on;
      logic [7:0]  wr_off;
      logic        wr_live;
      logic        sync1;
      logic        sync2;
      logic        async_lvl;
      logic [3:0]  async_cnt;
      dtc_term_t   sel;
      logic        trans;
      logic        wr_window;
   } dtc_state_t;

endpackage

// ### src/dtc_hist.sv
`timescale 1ns/1ps
// history of the termination pin, read back at a chosen depth
module dtc_hist #(
   parameter int DEPTH = 128,
   parameter int TAPW  = $clog2(DEPTH)
) (
   input  wire logic            clk,
   input  wire logic            rst_b,
   input  wire logic            din,
   input  wire logic [TAPW-1:0] tap,
   output      logic            dout
);
   typedef struct packed {
      logic [DEPTH-1:0] hist;
      logic             out;
   } dtc_hist_state_t;

   dtc_hist_state_t s;
   dtc_hist_state_t nxt;

   always_comb begin
      nxt      = s;
      nxt.hist = {s.hist[DEPTH-2:0], din};
      nxt.out  = s.hist[tap];
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= nxt;
      end
   end

   assign dout = s.out;
endmodule

// ### src/dtc_term_ctrl.sv
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "dtc_regs.svh"
// Operation
// - write termination starts write latency minus two, or three with long preamble
// - chop-four write ends termination 4, 7, 5 or 8 clocks after start
// - eight-beat write ends termination 6, 7, 7 or 8 clocks after start
// - with the delay-locked loop off, use asynchronous termination timing
// - asynchronous mode follows the pin without additive or parity latency
// - pin sampled high: leave park, reach nominal within the on window
// - pin sampled low: leave nominal, reach park within the off window
// - dynamic write termination only when a write-termination select bit is set
// - no dynamic write termination while the delay-locked loop is off
// - outside writes, pin low gives park, high gives nominal, direct latencies
module dtc_term_ctrl #(
   parameter int HIST_DEPTH = 128
) (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire dtc_pkg::dtc_avs_req_t  avs_req,
   output      dtc_pkg::dtc_avs_rsp_t  avs_rsp,
   input  wire dtc_pkg::dtc_link_t     link,
   output      dtc_pkg::dtc_term_out_t term_out
);
   import dtc_pkg::*;

   localparam int HIST_TAPW = $clog2(HIST_DEPTH);
   localparam int ASYNC_ON_RAW  = `DTC_ASYNC_ON_MAX_NS / `DTC_CLK_PERIOD_NS;
   localparam int ASYNC_OFF_RAW = `DTC_ASYNC_OFF_MAX_NS / `DTC_CLK_PERIOD_NS;
   // longest windows round down, never below one clock
   localparam int ASYNC_ON_CYC  = (ASYNC_ON_RAW < 1) ? 1 : ASYNC_ON_RAW;
   localparam int ASYNC_OFF_CYC = (ASYNC_OFF_RAW < 1) ? 1 : ASYNC_OFF_RAW;
   localparam logic [3:0] ASYNC_ON_CNT  = 4'(ASYNC_ON_CYC);
   localparam logic [3:0] ASYNC_OFF_CNT = 4'(ASYNC_OFF_CYC);
   localparam logic [7:0] HIST_MAX_TAP  = 8'(HIST_DEPTH - 1);

   dtc_state_t s;
   dtc_state_t nxt;

   logic                 dll_off;
   logic                 pre2;
   logic                 crc_on;
   logic [1:0]           wtsel;
   logic                 dyn_en;
   logic [7:0]           wr_lat;
   logic [7:0]           on_sub;
   logic [7:0]           on_lat;
   logic [7:0]           off_ext;
   logic [7:0]           off_lat;
   logic [7:0]           tap_raw;
   logic [HIST_TAPW-1:0] tap;
   logic                 nom_delayed;
   logic                 req;
   logic                 accept_wr;
   logic                 in_window;

   function automatic logic [31:0] dtc_be_merge(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0]  be
   );
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // register fields and derived latencies
   always_comb begin
      dll_off = s.ctrl[`DTC_CTRL_DLL_OFF];
      pre2    = s.ctrl[`DTC_CTRL_PRE2];
      crc_on  = s.ctrl[`DTC_CTRL_CRC];
      wtsel   = s.ctrl[`DTC_CTRL_WTSEL_HI:`DTC_CTRL_WTSEL_LO];
      dyn_en  = (|wtsel) && !dll_off;
      wr_lat  = 8'(s.lat[`DTC_LAT_CWL_HI:`DTC_LAT_CWL_LO])
              + 8'(s.lat[`DTC_LAT_AL_HI:`DTC_LAT_AL_LO])
              + 8'(s.lat[`DTC_LAT_PL_HI:`DTC_LAT_PL_LO]);
      on_sub  = pre2 ? `DTC_ON_SUB_PRE2 : `DTC_ON_SUB_PRE1;
      // saturate: a latency below the preamble shrink is meaningless
      on_lat  = (wr_lat > on_sub) ? (wr_lat - on_sub) : 8'h01;
      if (link.chop4) begin
         unique case ({pre2, crc_on})
            2'b00:   off_ext = `DTC_CHOP_P1_NOCRC;
            2'b01:   off_ext = `DTC_CHOP_P1_CRC;
            2'b10:   off_ext = `DTC_CHOP_P2_NOCRC;
            default: off_ext = `DTC_CHOP_P2_CRC;
         endcase
      end else begin
         unique case ({pre2, crc_on})
            2'b00:   off_ext = `DTC_FULL_P1_NOCRC;
            2'b01:   off_ext = `DTC_FULL_P1_CRC;
            2'b10:   off_ext = `DTC_FULL_P2_NOCRC;
            default: off_ext = `DTC_FULL_P2_CRC;
         endcase
      end
      off_lat = on_lat + off_ext;
      // two register stages follow the tap, so tap two clocks short
      tap_raw = (on_lat > 8'h02) ? (on_lat - 8'h02) : 8'h00;
      if (tap_raw > HIST_MAX_TAP) begin
         tap_raw = HIST_MAX_TAP;
      end
      tap = tap_raw[HIST_TAPW-1:0];
   end

   dtc_hist #(
      .DEPTH (HIST_DEPTH),
      .TAPW  (HIST_TAPW)
   ) u_hist (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (link.term_pin),
      .tap   (tap),
      .dout  (nom_delayed)
   );

   always_comb begin
      nxt       = s;
      req       = avs_req.read || avs_req.write;
      accept_wr = link.write_cmd && dyn_en;
      in_window = 1'b0;

      // bus slave: one wait cycle, then a one-cycle answer
      nxt.waitreq = 1'b1;
      if (req && s.waitreq) begin
         nxt.waitreq = 1'b0;
         nxt.rdata   = 32'h00000000;
         if (avs_req.read) begin
            unique case (avs_req.address)
               `DTC_OFS_CTRL:   nxt.rdata = s.ctrl;
               `DTC_OFS_LAT:    nxt.rdata = s.lat;
               `DTC_OFS_STATUS: begin
                  nxt.rdata[`DTC_STAT_SEL_HI:`DTC_STAT_SEL_LO] = s.sel;
                  nxt.rdata[`DTC_STAT_TRANS]                   = s.trans;
                  nxt.rdata[`DTC_STAT_WR_LIVE]                 = s.wr_live;
               end
               default:         nxt.rdata = 32'h00000000;
            endcase
         end
      end
      if (avs_req.write && !s.waitreq) begin
         unique case (avs_req.address)
            `DTC_OFS_CTRL: begin
               nxt.ctrl = dtc_be_merge(s.ctrl, avs_req.writedata, avs_req.byteenable)
                        & `DTC_CTRL_MASK;
            end
            `DTC_OFS_LAT: begin
               nxt.lat = dtc_be_merge(s.lat, avs_req.writedata, avs_req.byteenable)
                       & `DTC_LAT_MASK;
            end
            default: begin
            end
         endcase
      end

      // write window; latencies frozen at the command so later
      // register writes cannot stretch a window already running
      if (accept_wr) begin
         // count from the command edge so the switch lands on edge on_lat
         nxt.wr_cnt  = 8'h00;
         nxt.wr_live = 1'b1;
         nxt.wr_on   = on_lat;
         nxt.wr_off  = off_lat;
      end else if (s.wr_live) begin
         if (s.wr_cnt >= s.wr_off || dll_off) begin
            nxt.wr_live = 1'b0;
         end else begin
            nxt.wr_cnt = s.wr_cnt + 8'h01;
         end
      end
      in_window = nxt.wr_live && (nxt.wr_cnt >= nxt.wr_on) && (nxt.wr_cnt < nxt.wr_off);

      // pin synchroniser, only for the unlatched asynchronous path
      nxt.sync1 = link.term_pin;
      nxt.sync2 = s.sync1;
      if (s.sync2 != s.async_lvl) begin
         nxt.async_lvl = s.sync2;
         nxt.async_cnt = s.sync2 ? ASYNC_ON_CNT : ASYNC_OFF_CNT;
      end else if (s.async_cnt != 4'h0) begin
         nxt.async_cnt = s.async_cnt - 4'h1;
      end

      if (dll_off) begin
         nxt.sel       = nxt.async_lvl ? DTC_TERM_NOM : DTC_TERM_PARK;
         nxt.trans     = (nxt.async_cnt != 4'h0);
         nxt.wr_window = 1'b0;
      end else begin
         nxt.trans     = 1'b0;
         nxt.wr_window = in_window;
         if (in_window) begin
            nxt.sel = DTC_TERM_WR;
         end else if (nom_delayed) begin
            nxt.sel = DTC_TERM_NOM;
         end else begin
            nxt.sel = DTC_TERM_PARK;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s           <= '0;
         s.ctrl      <= `DTC_CTRL_RST;
         s.lat       <= `DTC_LAT_RST;
         s.waitreq   <= 1'b1;
         s.sel       <= DTC_TERM_PARK;
      end else begin
         s <= nxt;
      end
   end

   assign avs_rsp.waitrequest     = s.waitreq;
   assign avs_rsp.readdata        = s.rdata;
   assign term_out.sel            = s.sel;
   assign term_out.transitioning  = s.trans;
   assign term_out.wr_window      = s.wr_window;
endmodule

// ### sim/dtc_term_ctrl_properties.sv
`timescale 1ns/1ps
module dtc_term_ctrl_chk (
   input wire logic                   clk,
   input wire logic                   rst_b,
   input wire dtc_pkg::dtc_avs_req_t  avs_req,
   input wire dtc_pkg::dtc_avs_rsp_t  avs_rsp,
   input wire dtc_pkg::dtc_link_t     link,
   input wire dtc_pkg::dtc_term_out_t term_out
);
   import dtc_pkg::*;
   logic [4:0] ctrl_ff;
   // shadow of the control word; assumes whole-word writes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         ctrl_ff <= 5'h00;
      else if (avs_req.write && !avs_rsp.waitrequest && avs_req.address == 4'h0)
         ctrl_ff <= avs_req.writedata[4:0];
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   bus_answer_a: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest
      |=> !avs_rsp.waitrequest) else $error("bus request not answered next cycle");
   bus_single_a: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
      else $error("bus answer held longer than one cycle");
   wr_sel_a: assert property (term_out.wr_window |-> term_out.sel == DTC_TERM_WR)
      else $error("write window without write termination");
   wr_enable_a: assert property ($rose(term_out.wr_window) |-> ctrl_ff[4:3] != 2'h0)
      else $error("write termination with no select bit set");
   dll_nowr_a: assert property (ctrl_ff[0] && $past(ctrl_ff[0]) |-> !term_out.wr_window)
      else $error("write termination while loop is off");
   async_on_a: assert property ((ctrl_ff[0] && $rose(link.term_pin))
      ##1 (ctrl_ff[0] && link.term_pin)[*3] |-> term_out.sel == DTC_TERM_NOM)
      else $error("async nominal termination late");
   async_off_a: assert property ((ctrl_ff[0] && $fell(link.term_pin))
      ##1 (ctrl_ff[0] && !link.term_pin)[*3] |-> term_out.sel == DTC_TERM_PARK)
      else $error("async park termination late");
   trans_pulse_a: assert property ($rose(term_out.transitioning)
      |=> !term_out.transitioning) else $error("transition window too long");
endmodule

bind dtc_term_ctrl dtc_term_ctrl_chk chk_u (
   .clk      (clk),
   .rst_b    (rst_b),
   .avs_req  (avs_req),
   .avs_rsp  (avs_rsp),
   .link     (link),
   .term_out (term_out)
);

// ### sim/dtc_mc_model.sv
`timescale 1ns/1ps
module dtc_mc_model (
   input  wire logic          clk,
   output dtc_pkg::dtc_link_t link
);
   import dtc_pkg::*;
   initial link = '0;
   task automatic send_write(input logic chop);
      @(posedge clk);
      link.write_cmd <= 1'h1;
      link.chop4     <= chop;
      @(posedge clk);
      link.write_cmd <= 1'h0;
      // burst kind is only valid with the command, so scramble it after
      link.chop4     <= ~chop;
   endtask
   task automatic set_pin(input logic lvl);
      @(posedge clk);
      link.term_pin <= lvl;
   endtask
endmodule

// ### sim/tb_dtc_term_ctrl.sv
`timescale 1ns/1ps
`include "dtc_regs.svh"
module tb_dtc_term_ctrl;
   import dtc_pkg::*;
   logic          clk;
   logic          rst_b;
   logic          prev_wr;
   dtc_avs_req_t  req;
   dtc_avs_rsp_t  rsp;
   dtc_link_t     link;
   dtc_term_out_t tout;
   int            bad_count;
   int            samples_checked;
   int            cyc;
   int            t_cmd;
   int            t_on;
   int            t_off;
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   dtc_term_ctrl dut_u (.clk(clk), .rst_b(rst_b), .avs_req(req), .avs_rsp(rsp),
                        .link(link), .term_out(tout));
   dtc_mc_model mc_u (.clk(clk), .link(link));
   // edge stamps of command and window edges, values seen before each edge
   always @(posedge clk) begin
      if (link.write_cmd === 1'h1)
         t_cmd = cyc;
      if (tout.wr_window === 1'h1 && !prev_wr)
         t_on = cyc;
      if (tout.wr_window === 1'h0 && prev_wr)
         t_off = cyc;
      prev_wr = (tout.wr_window === 1'h1);
      cyc++;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      req.read      <= ~wr;
      req.write     <= wr;
      req.address   <= a;
      req.writedata <= d;
      // wait however long the answer takes; the watchdog ends a hang
      do begin
         @(posedge clk);
         n++;
      end while (rsp.waitrequest !== 1'h0);
      q = rsp.readdata;
      req.read  <= 1'h0;
      req.write <= 1'h0;
      // slave answers one cycle after taking the request
      check(n, 32'h2);
   endtask
   task automatic t_regs();
      logic [31:0] q;
      bus(1'h0, 4'h0, 32'h0, q);
      check(q, `DTC_CTRL_RST);
      bus(1'h0, 4'h4, 32'h0, q);
      check(q, `DTC_LAT_RST);
      bus(1'h1, 4'h4, 32'hFFFFFFFF, q);
      bus(1'h0, 4'h4, 32'h0, q);
      check(q, `DTC_LAT_MASK);
      // lane zero only: the upper bytes must survive
      req.byteenable <= 4'h1;
      bus(1'h1, 4'h4, 32'h00000000, q);
      req.byteenable <= 4'hF;
      bus(1'h0, 4'h4, 32'h0, q);
      check(q, 32'h000F3F00);
      bus(1'h1, 4'hC, 32'hFFFFFFFF, q);
      bus(1'h0, 4'hC, 32'h0, q);
      check(q, 32'h0);
      bus(1'h0, 4'h8, 32'h0, q);
      check(q, 32'h0);
   endtask
   // every preamble, crc and burst combination; wl = 9 + 1 + 1
   task automatic t_lat();
      int          chop_len[4] = '{4, 7, 5, 8};
      int          full_len[4] = '{6, 7, 7, 8};
      logic [31:0] q;
      bus(1'h1, 4'h4, 32'h00010109, q);
      for (int m = 0; m < 8; m++) begin
         bus(1'h1, 4'h0, {27'h0, 2'h1, m[0], m[1], 1'h0}, q);
         t_on  = -1;
         t_off = -1;
         mc_u.send_write(m[2]);
         repeat (30) @(posedge clk);
         check(t_on - t_cmd - 1, m[1] ? 8 : 9);
         check(t_off - t_on, m[2] ? chop_len[m[1:0]] : full_len[m[1:0]]);
         check(32'(tout.sel), 32'(DTC_TERM_PARK));
      end
   endtask
   task automatic t_nom();
      logic [31:0] q;
      bus(1'h1, 4'h0, 32'h08, q);
      mc_u.set_pin(1'h1);
      repeat (10) @(posedge clk);
      check(32'(tout.sel), 32'(DTC_TERM_PARK));
      @(posedge clk);
      check(32'(tout.sel), 32'(DTC_TERM_NOM));
      mc_u.send_write(1'h0);
      repeat (30) @(posedge clk);
      check(t_off - t_on, 32'h6);
      check(32'(tout.sel), 32'(DTC_TERM_NOM));
      mc_u.set_pin(1'h0);
      repeat (12) @(posedge clk);
   endtask
   // selects cleared, then loop off with selects set: no window either way
   task automatic t_gate();
      logic [31:0] q;
      logic [31:0] cfg[2] = '{32'h00, 32'h19};
      for (int i = 0; i < 2; i++) begin
         bus(1'h1, 4'h0, cfg[i], q);
         t_on = -1;
         mc_u.send_write(1'h0);
         repeat (30) @(posedge clk);
         check(t_on, 32'hFFFFFFFF);
      end
   endtask
   task automatic t_async();
      logic [31:0] q;
      bus(1'h1, 4'h0, 32'h01, q);
      mc_u.set_pin(1'h1);
      repeat (3) @(posedge clk);
      check(32'(tout.sel), 32'(DTC_TERM_PARK));
      @(posedge clk);
      check(32'(tout.sel), 32'(DTC_TERM_NOM));
      check(32'(tout.transitioning), 32'h1);
      @(posedge clk);
      check(32'(tout.transitioning), 32'h0);
      mc_u.set_pin(1'h0);
      repeat (4) @(posedge clk);
      check(32'(tout.sel), 32'(DTC_TERM_PARK));
      check(32'(tout.transitioning), 32'h1);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      rst_b = 1'h0;
      req = '0;
      req.byteenable = 4'hF;
      repeat (5) @(posedge clk);
      rst_b <= 1'h1;
      t_regs();
      t_lat();
      t_nom();
      t_gate();
      t_async();
      tally_and_finish();
   end
   // whole run is well under 2000 cycles
   initial begin
      #200000;
      bad_count++;
      tally_and_finish();
   end
endmodule
